// *** hdl/acpc_top.sv ***
// Clock divider, duty cycle stabilizer, power modes and output stage of the converter.
// Assumes sample clock, core result and serial port pins are synchronous to i_mclk.
`timescale 1ns/1ps
module acpc_top (
  input  wire logic                          i_mclk,
  input  wire logic                          i_rst,
  input  wire logic                          i_sample_clk,
  input  wire logic [acpc_pkg::DATA_W-1:0]  i_core_result,
  input  wire logic                          i_spi_sclk,
  input  wire logic                          i_spi_csb_n,
  input  wire logic                          i_sdio,
  output logic                               o_sdio,
  output logic                               o_sdio_oe,
  output logic      [acpc_pkg::DATA_W-1:0]  o_data,
  output logic                               o_data_oe,
  output logic                               o_data_capture_clock_out,
  output logic                               o_dcco_oe
);

  function automatic logic [acpc_pkg::DATA_W-1:0] encode(
    input logic [acpc_pkg::DATA_W-1:0] ob,
    input logic [1:0]                  fmt
  );
    logic [acpc_pkg::DATA_W-1:0] r;
    r = ob;
    if (fmt == acpc_pkg::FMT_TWOS_COMP)
    begin
      r = {~ob[acpc_pkg::DATA_W-1], ob[acpc_pkg::DATA_W-2:0]};
    end
    else if (fmt == acpc_pkg::FMT_GRAY)
    begin
      r = ob ^ (ob >> 1);
    end
    return r;
  endfunction : encode

  acpc_pkg::acpc_cfg_t         cfg_reg;
  acpc_pkg::acpc_pwr_state_t   pwr_reg;
  acpc_pkg::acpc_sp_state_t    sp_reg;
  logic                        sclk_q_reg;
  logic [4:0]                  bit_cnt_reg;
  logic [15:0]                 shift_reg;
  logic [12:0]                 addr_reg;
  logic                        rd_reg;
  logic [1:0]                  len_reg;
  logic [1:0]                  byte_cnt_reg;
  logic [7:0]                  tx_reg;
  logic                        smp_q_reg;
  logic [2:0]                  div_cnt_reg;
  logic                        raw_div_reg;
  logic [acpc_pkg::PER_W-1:0]  per_cnt_reg;
  logic [acpc_pkg::PER_W-1:0]  per_reg;
  logic [acpc_pkg::PER_W-1:0]  half_cnt_reg;
  logic                        dcs_clk_reg;
  logic [2:0]                  stable_reg;
  logic                        lock_reg;
  logic [acpc_pkg::WAKE_W-1:0] down_cnt_reg;
  logic [acpc_pkg::WAKE_W-1:0] wake_cnt_reg;
  logic [acpc_pkg::DLY_AW-1:0] wptr_reg;
  logic [acpc_pkg::DATA_W-1:0] dly_rdata;
  logic                        sclk_rise;
  logic                        sclk_fall;
  logic                        smp_rise;
  logic                        sample_edge;
  logic                        converting;
  logic                        dcs_en;
  logic [1:0]                  pwr_field;
  logic [7:0]                  rd_data;
  logic                        wr_byte;

  assign sclk_rise   = i_spi_sclk & ~sclk_q_reg;
  assign sclk_fall   = ~i_spi_sclk & sclk_q_reg;
  assign smp_rise    = i_sample_clk & ~smp_q_reg;
  assign dcs_en      = cfg_reg.clock_control[acpc_pkg::DCS_EN_BIT];
  assign pwr_field   = cfg_reg.power_mode_control[acpc_pkg::POWER_LSB +: 2];
  assign converting  = (pwr_reg == acpc_pkg::ACPC_RUN);
  assign sample_edge = converting && smp_rise &&
                       (div_cnt_reg == cfg_reg.clock_divide[acpc_pkg::DIV_LSB +: 3]);
  assign wr_byte     = (sp_reg == acpc_pkg::ACPC_SP_DATA) && sclk_rise && !rd_reg &&
                       (bit_cnt_reg == 5'(acpc_pkg::BYTE_BITS - 1));

  // Serial port readback decode
  always_comb
  begin
    rd_data = 8'h00;
    unique case (addr_reg)
      acpc_pkg::ADDR_POWER_MODE:  rd_data = cfg_reg.power_mode_control;
      acpc_pkg::ADDR_CLOCK_CTRL:  rd_data = {lock_reg, cfg_reg.clock_control[6:0]};
      acpc_pkg::ADDR_CLOCK_DIV:   rd_data = cfg_reg.clock_divide;
      acpc_pkg::ADDR_OUTPUT_MODE: rd_data = cfg_reg.output_mode_control;
      default:                    rd_data = 8'h00;
    endcase
  end

  // Serial port framing
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sclk_q_reg   <= 1'b0;
      sp_reg       <= acpc_pkg::ACPC_SP_IDLE;
      bit_cnt_reg  <= '0;
      shift_reg    <= '0;
      addr_reg     <= '0;
      rd_reg       <= 1'b0;
      len_reg      <= '0;
      byte_cnt_reg <= '0;
    end
    else
    begin
      sclk_q_reg <= i_spi_sclk;
      if (i_spi_csb_n)
      begin
        sp_reg      <= acpc_pkg::ACPC_SP_IDLE;
        bit_cnt_reg <= '0;
      end
      else if (sclk_rise)
      begin
        unique case (sp_reg)
          acpc_pkg::ACPC_SP_IDLE, acpc_pkg::ACPC_SP_INSTR:
          begin
            shift_reg   <= {shift_reg[14:0], i_sdio};
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            sp_reg      <= acpc_pkg::ACPC_SP_INSTR;
            if (bit_cnt_reg == 5'(acpc_pkg::INSTR_BITS - 1))
            begin
              rd_reg       <= shift_reg[14];
              len_reg      <= shift_reg[13:12];
              addr_reg     <= {shift_reg[11:0], i_sdio};
              byte_cnt_reg <= '0;
              bit_cnt_reg  <= '0;
              sp_reg       <= acpc_pkg::ACPC_SP_DATA;
            end
          end
          acpc_pkg::ACPC_SP_DATA:
          begin
            shift_reg   <= {shift_reg[14:0], i_sdio};
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == 5'(acpc_pkg::BYTE_BITS - 1))
            begin
              bit_cnt_reg  <= '0;
              addr_reg     <= addr_reg - 13'h0001;
              byte_cnt_reg <= byte_cnt_reg + 2'h1;
              if (len_reg != 2'h3 && byte_cnt_reg == len_reg)
              begin
                sp_reg <= acpc_pkg::ACPC_SP_DONE;
              end
            end
          end
          acpc_pkg::ACPC_SP_DONE:
          begin
            sp_reg <= acpc_pkg::ACPC_SP_DONE;
          end
        endcase
      end
    end
  end

  // Readback shifter, driven on falling serial clock edges
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tx_reg    <= '0;
      o_sdio    <= 1'b0;
      o_sdio_oe <= 1'b0;
    end
    else
    begin
      if (i_spi_csb_n || !rd_reg || sp_reg != acpc_pkg::ACPC_SP_DATA)
      begin
        o_sdio_oe <= 1'b0;
        tx_reg    <= rd_data;
      end
      else if (sclk_fall)
      begin
        o_sdio_oe <= 1'b1;
        o_sdio    <= (bit_cnt_reg == 5'h00) ? rd_data[7] : tx_reg[7];
        tx_reg    <= (bit_cnt_reg == 5'h00) ? {rd_data[6:0], 1'b0} : {tx_reg[6:0], 1'b0};
      end
    end
  end

  // Configuration registers
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cfg_reg.power_mode_control  <= acpc_pkg::POWER_MODE_RST;
      cfg_reg.clock_control       <= acpc_pkg::CLOCK_CTRL_RST;
      cfg_reg.clock_divide        <= acpc_pkg::CLOCK_DIV_RST;
      cfg_reg.output_mode_control <= acpc_pkg::OUTPUT_MODE_RST;
    end
    else if (wr_byte)
    begin
      unique case (addr_reg)
        acpc_pkg::ADDR_POWER_MODE:  cfg_reg.power_mode_control  <= {shift_reg[6:0], i_sdio};
        acpc_pkg::ADDR_CLOCK_CTRL:  cfg_reg.clock_control       <= {1'b0, shift_reg[5:0], i_sdio};
        acpc_pkg::ADDR_CLOCK_DIV:   cfg_reg.clock_divide        <= {5'h00, shift_reg[1:0], i_sdio};
        acpc_pkg::ADDR_OUTPUT_MODE: cfg_reg.output_mode_control <= {shift_reg[6:0], i_sdio};
        default:                    cfg_reg <= cfg_reg;
      endcase
    end
  end

  // Power mode sequencing
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pwr_reg      <= acpc_pkg::ACPC_RUN;
      down_cnt_reg <= '0;
      wake_cnt_reg <= '0;
    end
    else
    begin
      unique case (pwr_reg)
        acpc_pkg::ACPC_RUN:
        begin
          down_cnt_reg <= '0;
          if (pwr_field == acpc_pkg::PWR_DOWN)
          begin
            pwr_reg <= acpc_pkg::ACPC_DOWN;
          end
          else if (pwr_field == acpc_pkg::PWR_STANDBY)
          begin
            pwr_reg <= acpc_pkg::ACPC_STBY;
          end
        end
        acpc_pkg::ACPC_DOWN:
        begin
          if (down_cnt_reg != '1)
          begin
            down_cnt_reg <= down_cnt_reg + 1'b1;
          end
          if (pwr_field != acpc_pkg::PWR_DOWN)
          begin
            wake_cnt_reg <= (down_cnt_reg >> acpc_pkg::WAKE_SHIFT) + 1'b1;
            pwr_reg      <= acpc_pkg::ACPC_WAKE;
          end
        end
        acpc_pkg::ACPC_STBY:
        begin
          if (pwr_field == acpc_pkg::PWR_DOWN)
          begin
            pwr_reg <= acpc_pkg::ACPC_DOWN;
          end
          else if (pwr_field != acpc_pkg::PWR_STANDBY)
          begin
            wake_cnt_reg <= acpc_pkg::WAKE_W'(acpc_pkg::STBY_WAKE_CYC);
            pwr_reg      <= acpc_pkg::ACPC_WAKE;
          end
        end
        acpc_pkg::ACPC_WAKE:
        begin
          wake_cnt_reg <= wake_cnt_reg - 1'b1;
          if (pwr_field == acpc_pkg::PWR_DOWN)
          begin
            pwr_reg <= acpc_pkg::ACPC_DOWN;
          end
          else if (wake_cnt_reg <= acpc_pkg::WAKE_W'(1))
          begin
            pwr_reg <= acpc_pkg::ACPC_RUN;
          end
        end
      endcase
    end
  end

  // Input divider, clock stopped outside normal conversion
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      smp_q_reg   <= 1'b0;
      div_cnt_reg <= '0;
      raw_div_reg <= 1'b0;
    end
    else
    begin
      smp_q_reg <= i_sample_clk;
      if (!converting)
      begin
        div_cnt_reg <= '0;
        raw_div_reg <= 1'b0;
      end
      else if (smp_rise)
      begin
        div_cnt_reg <= sample_edge ? 3'h0 : div_cnt_reg + 3'h1;
        raw_div_reg <= sample_edge;
      end
      else if (!i_sample_clk)
      begin
        raw_div_reg <= 1'b0;
      end
    end
  end

  // Stabilizer: period measurement, rebuilt falling edge and lock
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      per_cnt_reg  <= '0;
      per_reg      <= '0;
      half_cnt_reg <= '0;
      dcs_clk_reg  <= 1'b0;
      stable_reg   <= '0;
      lock_reg     <= 1'b0;
    end
    else if (!converting || !dcs_en)
    begin
      per_cnt_reg <= '0;
      dcs_clk_reg <= 1'b0;
      stable_reg  <= '0;
      lock_reg    <= 1'b0;
    end
    else if (sample_edge)
    begin
      per_cnt_reg  <= acpc_pkg::PER_W'(1);
      per_reg      <= per_cnt_reg;
      half_cnt_reg <= acpc_pkg::PER_W'(1);
      dcs_clk_reg  <= 1'b1;
      if (per_cnt_reg == per_reg && per_cnt_reg <= acpc_pkg::PER_W'(acpc_pkg::DCS_MAX_PERIOD))
      begin
        if (stable_reg == 3'(acpc_pkg::DCS_STABLE_CNT))
        begin
          lock_reg <= 1'b1;
        end
        else
        begin
          stable_reg <= stable_reg + 3'h1;
        end
      end
      else
      begin
        stable_reg <= '0;
        lock_reg   <= 1'b0;
      end
    end
    else
    begin
      if (per_cnt_reg != '1)
      begin
        per_cnt_reg <= per_cnt_reg + 1'b1;
      end
      half_cnt_reg <= half_cnt_reg + 1'b1;
      if (half_cnt_reg >= (per_reg >> 1))
      begin
        dcs_clk_reg <= 1'b0;
      end
    end
  end

  // Sample history for the fixed latency
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wptr_reg <= '0;
    end
    else if (sample_edge)
    begin
      wptr_reg <= wptr_reg + 1'b1;
    end
  end

  acpc_delay_mem u_delay_mem (
    .i_mclk   (i_mclk),
    .i_rst    (i_rst),
    .i_strobe (sample_edge),
    .i_waddr  (wptr_reg),
    .i_raddr  (wptr_reg - acpc_pkg::DLY_AW'(acpc_pkg::LATENCY)),
    .i_wdata  (encode(i_core_result,
                      cfg_reg.output_mode_control[acpc_pkg::FORMAT_LSB +: 2])),
    .o_rdata  (dly_rdata)
  );

  // Output stage
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_data                   <= '0;
      o_data_oe                <= 1'b0;
      o_data_capture_clock_out <= 1'b0;
      o_dcco_oe                <= 1'b0;
    end
    else
    begin
      o_data    <= dly_rdata;
      o_dcco_oe <= (pwr_reg != acpc_pkg::ACPC_DOWN);
      o_data_oe <= (pwr_reg != acpc_pkg::ACPC_DOWN) &&
                   !cfg_reg.output_mode_control[acpc_pkg::OUT_DIS_BIT];
      o_data_capture_clock_out <= (dcs_en && lock_reg) ? dcs_clk_reg : raw_div_reg;
    end
  end

endmodule : acpc_top

// *** hdl/acpc_pkg.sv ***
// Package for the converter clock, power and output control block.
// Assumes a 100 MHz system clock and 14-bit offset-binary core results.
package acpc_pkg;

  // System clock
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS  = 10;

  // Register map
  localparam logic [12:0] ADDR_POWER_MODE  = 13'h0008;
  localparam logic [12:0] ADDR_CLOCK_CTRL  = 13'h0009;
  localparam logic [12:0] ADDR_CLOCK_DIV   = 13'h000B;
  localparam logic [12:0] ADDR_OUTPUT_MODE = 13'h0014;

  // Field positions
  localparam int unsigned POWER_LSB      = 0;
  localparam int unsigned DCS_EN_BIT     = 0;
  localparam int unsigned DCS_LOCK_BIT   = 7;
  localparam int unsigned DIV_LSB        = 0;
  localparam int unsigned FORMAT_LSB     = 0;
  localparam int unsigned OUT_DIS_BIT    = 4;

  // Reset values
  localparam logic [7:0] POWER_MODE_RST  = 8'h00;
  localparam logic [7:0] CLOCK_CTRL_RST  = 8'h01;
  localparam logic [7:0] CLOCK_DIV_RST   = 8'h00;
  localparam logic [7:0] OUTPUT_MODE_RST = 8'h01;

  // Power mode codes
  localparam logic [1:0] PWR_NORMAL      = 2'h0;
  localparam logic [1:0] PWR_DOWN        = 2'h1;
  localparam logic [1:0] PWR_STANDBY     = 2'h2;

  // Output formats
  localparam logic [1:0] FMT_OFFSET_BIN  = 2'h0;
  localparam logic [1:0] FMT_TWOS_COMP   = 2'h1;
  localparam logic [1:0] FMT_GRAY        = 2'h2;

  // Data path
  localparam int unsigned DATA_W         = 14;
  localparam int unsigned LATENCY        = 10;
  localparam int unsigned DLY_AW         = 4;
  localparam int unsigned DIV_MAX        = 8;

  // Serial port framing
  localparam int unsigned INSTR_BITS     = 16;
  localparam int unsigned BYTE_BITS      = 8;

  // Stabilizer
  localparam int unsigned DCS_MIN_HZ     = 40_000_000;
  localparam int unsigned DCS_MAX_PERIOD = CLK_HZ / DCS_MIN_HZ;
  localparam int unsigned DCS_STABLE_CNT = 4;
  localparam int unsigned PER_W          = 12;

  // Wake-up
  localparam int unsigned STBY_WAKE_NS   = 200;
  localparam int unsigned STBY_WAKE_CYC  = (STBY_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_SHIFT     = 4;
  localparam int unsigned WAKE_W         = 24;

  typedef enum logic [1:0] {
    ACPC_RUN,
    ACPC_DOWN,
    ACPC_STBY,
    ACPC_WAKE
  } acpc_pwr_state_t;

  typedef enum logic [1:0] {
    ACPC_SP_IDLE,
    ACPC_SP_INSTR,
    ACPC_SP_DATA,
    ACPC_SP_DONE
  } acpc_sp_state_t;

  typedef struct packed {
    logic [7:0] power_mode_control;
    logic [7:0] clock_control;
    logic [7:0] clock_divide;
    logic [7:0] output_mode_control;
  } acpc_cfg_t;

endpackage : acpc_pkg

// *** hdl/acpc_delay_mem.sv ***
// Small circular memory that holds encoded samples for the output latency.
// Assumes write and read share one strobe; read data come from a register.
`timescale 1ns/1ps
module acpc_delay_mem (
  input  wire logic                          i_mclk,
  input  wire logic                          i_rst,
  input  wire logic                          i_strobe,
  input  wire logic [acpc_pkg::DLY_AW-1:0]  i_waddr,
  input  wire logic [acpc_pkg::DLY_AW-1:0]  i_raddr,
  input  wire logic [acpc_pkg::DATA_W-1:0]  i_wdata,
  output logic      [acpc_pkg::DATA_W-1:0]  o_rdata
);

  logic [acpc_pkg::DATA_W-1:0] mem [2**acpc_pkg::DLY_AW];

  always_ff @(posedge i_mclk)
  begin
    if (i_strobe)
    begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Old word is read before the same strobe overwrites anything
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rdata <= '0;
    end
    else if (i_strobe)
    begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule : acpc_delay_mem

// *** tb/acpc_sva.sv ***
// Port checker for the converter clock, power and output block.
// Assumes it is bound onto acpc_top; one clock domain.
`timescale 1ns/1ps
module acpc_sva (
  input wire logic                         i_mclk,
  input wire logic                         i_rst,
  input wire logic                         i_sample_clk,
  input wire logic                         i_spi_sclk,
  input wire logic                         i_spi_csb_n,
  input wire logic                         o_sdio,
  input wire logic                         o_sdio_oe,
  input wire logic [acpc_pkg::DATA_W-1:0] o_data,
  input wire logic                         o_data_oe,
  input wire logic                         o_data_capture_clock_out,
  input wire logic                         o_dcco_oe
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  AST_DATA_NEEDS_PWR: assert property (o_data_oe |-> o_dcco_oe)
    else $error("data driven while capture clock floats");
  AST_RST_RUN: assert property ($fell(i_rst) |-> ##[0:1] (o_data_oe && o_dcco_oe))
    else $error("outputs not driven after reset");
  AST_DATA_UPD: assert property (
    $changed(o_data) && o_data_oe && $past(o_data_oe)
    |-> $past(i_sample_clk, 2) || $past(i_sample_clk, 3))
    else $error("data word changed away from a sampling edge");
  AST_SDIO_REL: assert property ($rose(i_spi_csb_n) |-> ##[1:2] !o_sdio_oe)
    else $error("read driver held after frame end");
  AST_SDIO_START: assert property (
    $rose(o_sdio_oe) |-> !$past(i_spi_csb_n, 1) && !$past(i_spi_csb_n, 2))
    else $error("read driver enabled outside a frame");
  AST_SDIO_SHIFT: assert property (
    $changed(o_sdio) && o_sdio_oe && $past(o_sdio_oe)
    |-> $past(i_spi_sclk, 2) && !$past(i_spi_sclk, 1))
    else $error("read bit moved away from a serial clock fall");
  AST_OEB_BY_CFG: assert property ($fell(o_data_oe) |-> !$past(i_spi_csb_n))
    else $error("data drivers released outside a write");
  AST_PWR_BY_CFG: assert property ($fell(o_dcco_oe) |-> !$past(i_spi_csb_n))
    else $error("power-down entered outside a write");
endmodule : acpc_sva

// *** tb/acpc_cap_model.sv ***
// Capture register on the far side of the sample outputs.
// Assumes the capture clock is seen through the system clock.
`timescale 1ns/1ps
module acpc_cap_model (
  input  wire logic                         i_mclk,
  input  wire logic                         i_rst,
  input  wire logic                         i_cap_clk,
  input  wire logic                         i_cap_oe,
  input  wire logic [acpc_pkg::DATA_W-1:0] i_word,
  input  wire logic                         i_word_oe,
  input  wire logic                         i_clr,
  output logic                              o_valid,
  output logic      [acpc_pkg::DATA_W-1:0] o_word,
  output logic      [7:0]                  o_rises
);
  logic                        clk_q;
  logic [acpc_pkg::DATA_W-1:0] last_q;
  logic [acpc_pkg::DATA_W-1:0] bus_w;

  // Floated bus toggles every cycle, between the inverted old word and the old word
  assign bus_w = i_word_oe ? i_word : ~last_q;

  always_ff @(posedge i_mclk or posedge i_rst)
    if (i_rst)
    begin
      clk_q   <= 1'b0;
      last_q  <= '0;
      o_valid <= 1'b0;
      o_word  <= '0;
      o_rises <= 8'h00;
    end
    else
    begin
      clk_q   <= i_cap_clk;
      last_q  <= bus_w;
      o_valid <= i_cap_oe && clk_q && !i_cap_clk;
      if (i_cap_oe && clk_q && !i_cap_clk)
        o_word <= bus_w;
      if (i_clr)
        o_rises <= 8'h00;
      else if (i_cap_oe && !clk_q && i_cap_clk)
        o_rises <= o_rises + 8'h01;
    end
endmodule : acpc_cap_model

// *** tb/adc_clock_power_output_control_bench.sv ***
// Self-checking bench for the converter clock, power and output block.
// Assumes acpc_top, acpc_cap_model and acpc_sva are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module adc_clock_power_output_control_bench;
  localparam int W = acpc_pkg::DATA_W;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         sclk = 1'b0;
  logic         csb_n = 1'b1;
  logic         sdi = 1'b0;
  logic         smp = 1'b0;
  logic         clr = 1'b0;
  logic [W-1:0] core = '0;
  logic         sdo, sdo_oe, oe, dcc, dcc_oe, mv;
  logic [W-1:0] dat, mw, e;
  logic [7:0]   rises;
  logic [W-1:0] q[$];
  logic [W-1:0] bt[3] = '{14'h0000, 14'h2000, 14'h3FFF};
  logic [31:0]  rs = 32'h760F1B70;
  logic [1:0]   fmt = 2'h1;
  bit           run = 1'b0;
  bit           chk = 1'b1;
  int           n_fail, checks, n, half = 3, cnt, bnd, skip = 10;
  int           wt[2];
  wire          io = sdo_oe ? sdo : sdi;

  always #5 clk = ~clk;

  acpc_top uut (
    .i_mclk                   (clk),
    .i_rst                    (rst),
    .i_sample_clk             (smp),
    .i_core_result            (core),
    .i_spi_sclk               (sclk),
    .i_spi_csb_n              (csb_n),
    .i_sdio                   (io),
    .o_sdio                   (sdo),
    .o_sdio_oe                (sdo_oe),
    .o_data                   (dat),
    .o_data_oe                (oe),
    .o_data_capture_clock_out (dcc),
    .o_dcco_oe                (dcc_oe)
  );
  acpc_cap_model u_cap (.i_mclk(clk), .i_rst(rst), .i_cap_clk(dcc), .i_cap_oe(dcc_oe),
    .i_word(dat), .i_word_oe(oe), .i_clr(clr), .o_valid(mv), .o_word(mw), .o_rises(rises));

  function automatic logic [W-1:0] enc(input logic [W-1:0] v, input logic [1:0] f);
    case (f)
      2'h1: return v ^ 14'h2000;
      2'h2: return v ^ (v >> 1);
      default: return v;
    endcase
  endfunction : enc

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  // Sample clock and core words; a note per sample
  always @(negedge clk)
  begin
    if (!run)
    begin
      smp = 1'b0;
      cnt = 0;
    end
    else if (cnt < half - 1)
      cnt++;
    else
    begin
      cnt = 0;
      smp = ~smp;
      if (smp)
      begin
        rs = xs(rs);
        core = (bnd < 3) ? bt[bnd] : rs[W-1:0];
        bnd++;
        if (chk) q.push_back(enc(core, fmt));
      end
    end
  end

  always @(posedge clk)
    if (mv && chk)
    begin
      if (skip > 0) skip--;
      else if (q.size() == 0) `CHK(1'b0, 1'b1)
      else
      begin
        e = q.pop_front();
        `CHK(mw, e)
      end
    end

  task automatic spi(input logic [15:0] ins, input logic [7:0] wd, output logic [7:0] rd);
    logic [23:0] sh;
    sh = {ins, wd};
    csb_n = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      sdi = sh[i];
      sclk = 1'b0;
      repeat (3) @(negedge clk);
      rd = {rd[6:0], io};
      sclk = 1'b1;
      repeat (3) @(negedge clk);
    end
    sclk = 1'b0;
    repeat (3) @(negedge clk);
    csb_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask : spi

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] r;
    spi({3'b000, a}, d, r);
  endtask : wr

  task automatic rdc(input logic [12:0] a, input logic [7:0] x);
    logic [7:0] r;
    spi({3'b100, a}, 8'h00, r);
    `CHK(r, x)
  endtask : rdc

  task automatic stop();
    run = 1'b0;
    repeat (10) @(negedge clk);
  endtask : stop

  task automatic test_done();
    $display("checks %0d errors %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  initial
  begin
    repeat (100000) @(posedge clk);
    n_fail++;
    test_done();
  end

  initial
  begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    run = 1'b1;
    @(negedge clk);
    `CHK({oe, dcc_oe}, 2'b11)
    rdc(13'h0008, 8'h00);
    rdc(13'h0009, 8'h01);
    rdc(13'h000B, 8'h00);
    rdc(13'h0014, 8'h01);
    wr(13'h0013, 8'hFF);
    rdc(13'h0013, 8'h00);
    wr(13'h0009, 8'h80);
    rdc(13'h0009, 8'h00);
    wr(13'h0009, 8'h01);
    for (int f = 0; f < 4; f++)
    begin
      stop();
      wr(13'h0014, 8'(f));
      fmt = f[1:0];
      bnd = 0;
      run = 1'b1;
      repeat (200) @(negedge clk);
    end
    stop();
    wr(13'h0014, 8'h11);
    `CHK({oe, dcc_oe}, 2'b01)
    wr(13'h0014, 8'h01);
    `CHK(oe, 1'b1)
    fmt = 2'h1;
    run = 1'b1;
    repeat (100) @(negedge clk);
    stop();
    chk = 1'b0;
    for (int r = 1; r <= 8; r++)
    begin
      wr(13'h000B, 8'(r - 1));
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      run = 1'b1;
      repeat (144) @(negedge clk);
      stop();
      `CHK(rises >= 24 / r - 1 && rises <= 24 / r + 1, 1'b1)
    end
    wr(13'h000B, 8'h00);
    half = 1;
    run = 1'b1;
    repeat (500) @(negedge clk);
    rdc(13'h0009, 8'h81);
    half = 3;
    repeat (500) @(negedge clk);
    rdc(13'h0009, 8'h01);
    for (int k = 0; k < 2; k++)
    begin
      stop();
      wr(13'h0008, 8'h01);
      `CHK({oe, dcc_oe}, 2'b00)
      repeat (160 + 640 * k) @(negedge clk);
      wr(13'h0008, 8'h00);
      run = 1'b1;
      n = 0;
      while (!mv && n < 3000)
      begin
        @(negedge clk);
        n++;
      end
      if (n == 3000)
      begin
        n_fail++;
        test_done();
      end
      wt[k] = n;
    end
    `CHK(wt[1] - wt[0] >= 34 && wt[1] - wt[0] <= 46, 1'b1)
    wr(13'h0008, 8'h02);
    `CHK(oe, 1'b1)
    repeat (10) @(negedge clk);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    repeat (100) @(negedge clk);
    `CHK(rises, 8'h00)
    wr(13'h0008, 8'h03);
    repeat (100) @(negedge clk);
    `CHK(rises != 8'h00, 1'b1)
    stop();
    q.delete();
    skip = 10;
    chk = 1'b1;
    run = 1'b1;
    repeat (300) @(negedge clk);
    test_done();
  end
endmodule : adc_clock_power_output_control_bench

bind acpc_top acpc_sva u_sva (
  .i_mclk                   (i_mclk),
  .i_rst                    (i_rst),
  .i_sample_clk             (i_sample_clk),
  .i_spi_sclk               (i_spi_sclk),
  .i_spi_csb_n              (i_spi_csb_n),
  .o_sdio                   (o_sdio),
  .o_sdio_oe                (o_sdio_oe),
  .o_data                   (o_data),
  .o_data_oe                (o_data_oe),
  .o_data_capture_clock_out (o_data_capture_clock_out),
  .o_dcco_oe                (o_dcco_oe)
);
